// ===== sep_pkg.sv
package sep_pkg;

  // ********************************************
  // Array and byte layout
  // ********************************************
  localparam int unsigned ADDR_W = 9;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 9'h1FF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Device type prefix, value arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam int unsigned CTL_TYPE_HI = 7;
  localparam int unsigned CTL_TYPE_LO = 4;
  localparam int unsigned CTL_SEL_TWO = 3;
  localparam int unsigned CTL_TOP_BIT = 2;
  localparam int unsigned CTL_SEL_ZERO = 1;
  localparam int unsigned CTL_DIR = 0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  // ********************************************
  // Timing
  // ********************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ERASE_TIME_US = 5000;
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned TOTAL_TIME_US = 20000;
  localparam int unsigned POR_TIME_US = 100;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned TOTAL_CYC = TOTAL_TIME_US * CLK_MHZ;
  localparam int unsigned POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W = 21;

  // ********************************************
  // State encodings
  // ********************************************
  typedef enum logic [2:0] {
    SEP_IDLE = 3'b000,
    SEP_CTRL = 3'b001,
    SEP_ADDR = 3'b010,
    SEP_DATA = 3'b011,
    SEP_READ = 3'b100,
    SEP_WAIT = 3'b101
  } sep_bus_t;

  typedef enum logic [1:0] {
    SEP_P_IDLE = 2'b00,
    SEP_P_ERASE = 2'b01,
    SEP_P_WRITE = 2'b10,
    SEP_P_TOTAL = 2'b11
  } sep_prog_t;

endpackage

// ===== sep_eeprom_slave.sv
`timescale 1ns/10ps
// How it works
// R1: SDA edge while SCL high: start/stop
// R2: Drive SDA only after SCL falls
// R3: Ack from eighth fall through ninth clock
// R4: Release SDA on ninth clock when sending
// R5: Master sends three bytes after start
// R6: Master clocks nine per read byte
// R7: Stop after 27th clock starts programming
// R8: Respond only when select bits match pins
// R9: Write control word carries address top bit
// R10: Write control word while busy aborts programming
// R11: Read control word while busy: no ack
// R12: Master reads via address write, restart
// R13: Load word on ninth clock, shift out
// R14: Master ack low advances address counter
// R15: Address counter wraps 511 to 0
// R16: Stop releases SDA and idles sequencer
// R17: Erase word to ones, then write zeros
// R18: Word programming finishes within 20 ms
// R19: Skip write if no zeros, skip erase
// R20: Power-on hold rejects programming, bytes still acked
// R21: Select two open at stop: total erase; the code also needs address 0 and data FF
// R22: Select zero open: protect, match zero only
// R23: Control word: type, selects, direction bit
// R24: Master polls busy with read control word
// R25: All bytes travel MSB first
module sep_eeprom_slave
  import sep_pkg::*;
#(
  parameter int unsigned EraseCycles = ERASE_CYC,
  parameter int unsigned WriteCycles = WRITE_CYC,
  parameter int unsigned TotalCycles = TOTAL_CYC,
  parameter int unsigned PorCycles = POR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic selPinZero,
  input wire logic selPinZeroOpen,
  input wire logic selPinTwo,
  input wire logic selPinTwoOpen,
  output logic progBusy,
  output logic porHold
);

  // ********************************************
  // Link domain: sample SDA on each SCL rise
  // ********************************************
  typedef struct packed {
    logic tog;
    logic bitVal;
  } sep_link_t;

  sep_link_t lnk_ff;
  sep_link_t nxt_lnk;

  always_comb begin
    nxt_lnk = lnk_ff;
    nxt_lnk.tog = ~lnk_ff.tog;
    nxt_lnk.bitVal = sdaIn; // R2
    if (rst) begin
      nxt_lnk = '0;
    end
  end

  // Cleared only by scl rises while rst is high
  always_ff @(posedge scl) begin
    lnk_ff <= nxt_lnk;
  end

  // ********************************************
  // Core domain state
  // ********************************************
  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] togSync;
    logic [1:0] bitSync;
    // Select pin levels, two stages
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic togSeen;
    logic sclPrev;
    logic sdaPrev;
    sep_bus_t bus;
    logic [3:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dataReg;
    logic readDir;
    logic keepReading;
    logic writeReady;
    logic drvLow;
    sep_prog_t prog;
    logic [ADDR_W-1:0] progAddr;
    logic [7:0] progData;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] porCnt;
  } sep_core_t;

  sep_core_t st_ff;
  sep_core_t nxt_st;

  logic [7:0] memArr [0:(1 << ADDR_W)-1];
  logic memWrEn;
  logic memClrAll;
  logic [ADDR_W-1:0] memWrAddr;
  logic [7:0] memWrData;

  // Timers count down to zero, so load one less
  function automatic logic [TMR_W-1:0] cyc_to_tmr(input int unsigned cyc);
    cyc_to_tmr = TMR_W'(cyc - 1);
  endfunction

  function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
    if (a == ADDR_LAST) begin
      addr_next = ADDR_ZERO; // R15
    end else begin
      addr_next = a + ADDR_W'(1);
    end
  endfunction

  always_comb begin
    logic sclHigh;
    logic sdaLvl;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic busy;
    logic selMatch;
    logic [7:0] ctlByte;
    logic pinZero;
    logic pinZeroOpen;
    logic pinTwo;
    logic pinTwoOpen;

    pinZero = st_ff.pinSync[0];
    pinZeroOpen = st_ff.pinSync[1];
    pinTwo = st_ff.pinSync[2];
    pinTwoOpen = st_ff.pinSync[3];
    sclHigh = st_ff.sclSync[1];
    sdaLvl = st_ff.sdaSync[1];
    // Each scl rise flips the link toggle, seen here two flops later
    sclRise = st_ff.togSync[1] != st_ff.togSeen;
    sclFall = st_ff.sclPrev & ~sclHigh;
    // Scl must be high on two samples, so data moves never look like start
    startCond = sclHigh & st_ff.sclPrev & st_ff.sdaPrev & ~sdaLvl; // R1
    stopCond = sclHigh & st_ff.sclPrev & ~st_ff.sdaPrev & sdaLvl; // R1
    busy = st_ff.prog != SEP_P_IDLE;
    ctlByte = st_ff.rxShift;
    selMatch = (ctlByte[CTL_TYPE_HI:CTL_TYPE_LO] == DEV_TYPE) // R23
      && (pinTwoOpen || ctlByte[CTL_SEL_TWO] == pinTwo) // R8
      && (pinZeroOpen ? ~ctlByte[CTL_SEL_ZERO] : ctlByte[CTL_SEL_ZERO] == pinZero); // R22
    memWrEn = 1'b0;
    memClrAll = 1'b0;
    memWrAddr = st_ff.progAddr;
    memWrData = ERASED_BYTE;

    nxt_st = st_ff;
    nxt_st.sclSync = {st_ff.sclSync[0], scl};
    nxt_st.sdaSync = {st_ff.sdaSync[0], sdaIn};
    nxt_st.togSync = {st_ff.togSync[0], lnk_ff.tog};
    nxt_st.bitSync = {st_ff.bitSync[0], lnk_ff.bitVal};
    nxt_st.togSeen = st_ff.togSync[1];
    nxt_st.sclPrev = sclHigh;
    nxt_st.sdaPrev = sdaLvl;
    // Select pins pass two flops before any decode
    nxt_st.pinMeta = {selPinTwoOpen, selPinTwo, selPinZeroOpen, selPinZero};
    nxt_st.pinSync = st_ff.pinMeta;

    // ********************************************
    // Power-on hold
    // ********************************************
    // Programming is refused until this count runs out
    if (st_ff.porCnt != '0) begin
      nxt_st.porCnt = st_ff.porCnt - TMR_W'(1);
    end

    // ********************************************
    // Bus sequencer
    // ********************************************
    if (startCond) begin
      nxt_st.bus = SEP_CTRL;
      nxt_st.bitCnt = '0;
      nxt_st.drvLow = 1'b0;
      nxt_st.writeReady = 1'b0;
    end else if (stopCond) begin
      nxt_st.bus = SEP_IDLE; // R16
      nxt_st.drvLow = 1'b0; // R16
      nxt_st.writeReady = 1'b0;
      // Stop after a complete data byte starts programming
      if (st_ff.writeReady && !busy && st_ff.porCnt == '0 && !pinZeroOpen) begin // R7 R20 R22
        nxt_st.progAddr = st_ff.addr;
        nxt_st.progData = st_ff.dataReg;
        if (pinTwoOpen && st_ff.addr == ADDR_ZERO && st_ff.dataReg == ERASED_BYTE) begin
          nxt_st.prog = SEP_P_TOTAL; // R21
          nxt_st.timer = cyc_to_tmr(TotalCycles);
        end else if (memArr[st_ff.addr] != ERASED_BYTE) begin
          nxt_st.prog = SEP_P_ERASE; // R17
          nxt_st.timer = cyc_to_tmr(EraseCycles);
        end else if (st_ff.dataReg != ERASED_BYTE) begin
          nxt_st.prog = SEP_P_WRITE; // R19
          nxt_st.timer = cyc_to_tmr(WriteCycles);
        end
      end
    end else begin
      case (st_ff.bus)
        SEP_CTRL, SEP_ADDR, SEP_DATA: begin
          if (sclRise) begin
            if (st_ff.bitCnt < BIT_LAST) begin
              nxt_st.rxShift = {st_ff.rxShift[6:0], st_ff.bitSync[1]}; // R25
              nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
            end else if (st_ff.bitCnt == BIT_LAST) begin
              nxt_st.bitCnt = BIT_ACK;
              if (st_ff.bus == SEP_CTRL && st_ff.readDir) begin
                nxt_st.txShift = memArr[st_ff.addr]; // R13
              end
            end
          end else if (sclFall && st_ff.bitCnt == BIT_LAST) begin
            nxt_st.drvLow = 1'b1; // R3
            case (st_ff.bus)
              SEP_CTRL: begin
                nxt_st.readDir = ctlByte[CTL_DIR];
                if (!selMatch) begin
                  nxt_st.bus = SEP_WAIT;
                  nxt_st.drvLow = 1'b0; // R8
                end else if (ctlByte[CTL_DIR] && busy) begin
                  nxt_st.bus = SEP_WAIT;
                  nxt_st.drvLow = 1'b0; // R11
                end else if (!ctlByte[CTL_DIR]) begin
                  nxt_st.addr[ADDR_W-1] = ctlByte[CTL_TOP_BIT]; // R9
                  if (busy) begin
                    nxt_st.prog = SEP_P_IDLE; // R10
                  end
                end
              end
              SEP_ADDR: nxt_st.addr[7:0] = st_ff.rxShift;
              SEP_DATA: nxt_st.dataReg = st_ff.rxShift;
              default: nxt_st.drvLow = 1'b0;
            endcase
          end else if (sclFall && st_ff.bitCnt == BIT_ACK) begin
            nxt_st.drvLow = 1'b0;
            nxt_st.bitCnt = '0;
            case (st_ff.bus)
              SEP_CTRL: begin
                if (st_ff.readDir) begin
                  nxt_st.bus = SEP_READ;
                  nxt_st.drvLow = ~st_ff.txShift[7]; // R13
                end else begin
                  nxt_st.bus = SEP_ADDR;
                end
              end
              SEP_ADDR: nxt_st.bus = SEP_DATA;
              default: begin
                nxt_st.bus = SEP_WAIT;
                nxt_st.writeReady = 1'b1; // R7
              end
            endcase
          end
        end
        SEP_READ: begin
          if (sclRise) begin
            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
            if (st_ff.bitCnt == BIT_LAST) begin
              nxt_st.keepReading = ~st_ff.bitSync[1];
              if (!st_ff.bitSync[1]) begin
                nxt_st.addr = addr_next(st_ff.addr); // R14
                // Next word is fetched at the ack rise, ahead of the fall
                nxt_st.txShift = memArr[addr_next(st_ff.addr)];
              end
            end
          end else if (sclFall) begin
            if (st_ff.bitCnt < BIT_LAST) begin
              nxt_st.drvLow = ~st_ff.txShift[3'h7 - st_ff.bitCnt[2:0]]; // R2 R25
            end else if (st_ff.bitCnt == BIT_LAST) begin
              nxt_st.drvLow = 1'b0; // R4
            end else if (st_ff.keepReading) begin
              nxt_st.bitCnt = '0;
              nxt_st.drvLow = ~st_ff.txShift[7];
            end else begin
              nxt_st.bus = SEP_WAIT;
              nxt_st.drvLow = 1'b0;
            end
          end
        end
        SEP_IDLE, SEP_WAIT: nxt_st.drvLow = 1'b0;
        default: begin
          nxt_st.bus = SEP_IDLE;
          nxt_st.drvLow = 1'b0;
        end
      endcase
    end

    // ********************************************
    // Programming sequencer
    // ********************************************
    // An abort seen this cycle stops the timer
    if (st_ff.prog != SEP_P_IDLE && nxt_st.prog != SEP_P_IDLE && !(stopCond && !busy)) begin
      if (st_ff.timer != '0) begin
        nxt_st.timer = st_ff.timer - TMR_W'(1); // R18
      end else begin
        case (st_ff.prog)
          SEP_P_ERASE: begin
            memWrEn = 1'b1; // R17
            memWrData = ERASED_BYTE;
            if (st_ff.progData != ERASED_BYTE) begin
              nxt_st.prog = SEP_P_WRITE;
              nxt_st.timer = cyc_to_tmr(WriteCycles);
            end else begin
              nxt_st.prog = SEP_P_IDLE; // R19
            end
          end
          SEP_P_WRITE: begin
            memWrEn = 1'b1;
            memWrData = ERASED_BYTE & st_ff.progData; // R17
            nxt_st.prog = SEP_P_IDLE;
          end
          SEP_P_TOTAL: begin
            memClrAll = 1'b1; // R21
            nxt_st.prog = SEP_P_IDLE;
          end
          default: nxt_st.prog = SEP_P_IDLE;
        endcase
      end
    end

    if (rst) begin
      nxt_st = '0;
      nxt_st.sclSync = 2'b11;
      nxt_st.sdaSync = 2'b11;
      nxt_st.sclPrev = 1'b1;
      nxt_st.sdaPrev = 1'b1;
      nxt_st.togSync = {2{lnk_ff.tog}};
      nxt_st.togSeen = lnk_ff.tog;
      nxt_st.bus = SEP_IDLE;
      nxt_st.prog = SEP_P_IDLE;
      nxt_st.porCnt = cyc_to_tmr(PorCycles); // R20
      memWrEn = 1'b0;
      memClrAll = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // ********************************************
  // Memory array
  // ********************************************
  always_ff @(posedge clk) begin
    // Total erase sets every word in one clock
    if (memClrAll) begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
        memArr[i] <= ERASED_BYTE;
      end
    end else if (memWrEn) begin
      memArr[memWrAddr] <= memWrData;
    end
  end

  // Open drain: the pin only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = st_ff.drvLow; // R20
  assign progBusy = st_ff.prog != SEP_P_IDLE;
  assign porHold = st_ff.porCnt != '0;

endmodule

// ===== sep_eeprom_slave_props.sv
`timescale 1ns/10ps
module sep_eeprom_slave_props
  import sep_pkg::*;
#(
  parameter int unsigned TotalCycles = TOTAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic selPinZero,
  input wire logic selPinZeroOpen,
  input wire logic selPinTwo,
  input wire logic selPinTwoOpen,
  input wire logic progBusy,
  input wire logic porHold
);
  // ****************
  // Busy length
  // ****************
  logic [31:0] busyCnt_ff;
  always_ff @(posedge clk) begin
    if (rst || !progBusy) begin
      busyCnt_ff <= '0;
    end else begin
      busyCnt_ff <= busyCnt_ff + 32'h0000_0001;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence porWindow;
    porHold [*8];
  endsequence
  sequence busyHeld;
    progBusy [*8];
  endsequence
  sequence oeHeld;
    sdaOe [*8];
  endsequence
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("sda output not low");
  por_hold_len_a: assert property ($fell(rst) |-> porWindow)
    else $error("power-on hold too short");
  por_no_prog_a: assert property (porHold |-> !progBusy)
    else $error("programming during power-on hold");
  protect_prog_a: assert property ($rose(progBusy) |-> !selPinZeroOpen && !$past(porHold))
    else $error("programming while protected");
  busy_min_a: assert property ($rose(progBusy) |-> busyHeld)
    else $error("programming ended too soon");
  busy_max_a: assert property (busyCnt_ff <= 32'(TotalCycles + 4))
    else $error("programming too long");
  oe_rise_low_a: assert property ($rose(sdaOe) |-> !scl ##1 oeHeld)
    else $error("sda pulled at wrong time");
  oe_fall_low_a: assert property ($fell(sdaOe) |-> !scl)
    else $error("sda released while scl high");
endmodule

bind sep_eeprom_slave sep_eeprom_slave_props #(.TotalCycles(TotalCycles)) u_props (
  .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .selPinZero(selPinZero), .selPinZeroOpen(selPinZeroOpen), .selPinTwo(selPinTwo),
  .selPinTwoOpen(selPinTwoOpen), .progBusy(progBusy), .porHold(porHold));

// ===== sep_i2c_master.sv
`timescale 1ns/10ps
module sep_i2c_master (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    // Two idle clocks while reset is held clear the link side
    repeat (2) begin
      #20 scl = 1'b0;
      #20 scl = 1'b1;
    end
  end
  task automatic start();
    #20 sdaDrv = 1'b1;
    #50 scl = 1'b1;
    #125 sdaDrv = 1'b0;
    #125 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sdaDrv = 1'b0;
    #30 scl = 1'b1;
    #125 sdaDrv = 1'b1;
    #80;
  endtask
  // Data moves in the low phase only, sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    #20 sdaDrv = b;
    #42.5 scl = 1'b1;
    #31 r = sdaWire;
    #31.5 scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask
endmodule

// ===== test_serial_eeprom_slave_512x8.sv
`timescale 1ns/10ps
module test_serial_eeprom_slave_512x8
  import sep_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic selPinZero = 1'b1;
  logic selPinZeroOpen = 1'b0;
  logic selPinTwo = 1'b0;
  logic selPinTwoOpen = 1'b0;
  logic sdaOut, sdaOe, progBusy, porHold, scl, sdaDrv, k;
  logic sdaWire;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  sep_eeprom_slave #(.EraseCycles(200), .WriteCycles(200), .TotalCycles(400), .PorCycles(600)) dut (
    .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .selPinZero(selPinZero), .selPinZeroOpen(selPinZeroOpen), .selPinTwo(selPinTwo),
    .selPinTwoOpen(selPinTwoOpen), .progBusy(progBusy), .porHold(porHold));
  sep_i2c_master mst (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  // ****************
  // Access tasks
  // ****************
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ctl(input logic dir, input logic a8, input logic s0);
    return {DEV_TYPE, 1'b0, a8, s0, dir};
  endfunction
  task automatic idle();
    for (int i = 0; i < 600 && progBusy !== 1'b0; i++) @(posedge clk);
    chk({7'h0, progBusy}, 8'h00);
    @(posedge clk) selPinTwoOpen <= 1'b0;
  endtask
  task automatic head(input logic [8:0] a, input logic s0, output logic [1:0] ak);
    idle();
    mst.start();
    mst.wbyte(ctl(1'b0, a[8], s0), ak[1]);
    mst.wbyte(a[7:0], ak[0]);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic te, input logic eb);
    logic [1:0] ak;
    logic k;
    head(a, ~selPinZeroOpen, ak);
    mst.wbyte(d, k);
    chk({5'h0, ak, k}, 8'h07);
    @(posedge clk) selPinTwoOpen <= te;
    mst.stop();
    chk({7'h0, progBusy}, {7'h0, eb});
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [1:0] ak;
    logic k;
    logic [7:0] d0, d1;
    head(a, 1'b1, ak);
    mst.start();
    mst.wbyte(ctl(1'b1, 1'b0, 1'b1), k);
    mst.rbyte(1'b0, d0);
    mst.rbyte(1'b1, d1);
    mst.stop();
    chk({5'h0, ak, k}, 8'h07);
    chk(d0, e0);
    chk(d1, e1);
    chk({7'h0, sdaOe}, 8'h00);
  endtask
  // ****************
  // Sequence
  // ****************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    wr(9'h000, 8'h00, 1'b0, 1'b0);
    chk({7'h0, porHold}, 8'h01);
    for (int i = 0; i < 700 && porHold !== 1'b0; i++) @(posedge clk);
    chk({7'h0, porHold}, 8'h00);
    wr(9'h000, ERASED_BYTE, 1'b1, 1'b1);
    rd(ADDR_LAST, 8'hFF, 8'hFF);
    wr(ADDR_LAST, 8'hFF, 1'b0, 1'b0);
    wr(ADDR_LAST, 8'h3C, 1'b0, 1'b1);
    wr(9'h000, 8'hC3, 1'b0, 1'b1);
    wr(9'h105, 8'hA5, 1'b0, 1'b1);
    mst.start();
    mst.wbyte(ctl(1'b1, 1'b0, 1'b1), k);
    chk({7'h0, k}, 8'h00);
    mst.stop();
    rd(ADDR_LAST, 8'h3C, 8'hC3);
    rd(9'h105, 8'hA5, 8'hFF);
    idle();
    mst.start();
    mst.wbyte(ctl(1'b0, 1'b0, 1'b0), k);
    chk({7'h0, k}, 8'h00);
    mst.stop();
    @(posedge clk) selPinZeroOpen <= 1'b1;
    mst.start();
    mst.wbyte(ctl(1'b0, 1'b0, 1'b1), k);
    chk({7'h0, k}, 8'h00);
    mst.stop();
    wr(9'h105, 8'h00, 1'b0, 1'b0);
    @(posedge clk) selPinZeroOpen <= 1'b0;
    rd(9'h105, 8'hA5, 8'hFF);
    wr(9'h105, 8'h00, 1'b0, 1'b1);
    mst.start();
    mst.wbyte(ctl(1'b0, 1'b1, 1'b1), k);
    chk({6'h0, k, progBusy}, 8'h02);
    mst.stop();
    idle();
    end_of_test();
  end
endmodule
